// File: inc/ep_regs_pkg.sv
`default_nettype none
package ep_regs_pkg;
    // Register offsets on the CPU I/O space
    localparam logic [7:0] OFS_CTRL_A_COUNTER = 8'h11;
    localparam logic [7:0] OFS_CTRL_A_MODE = 8'h12;
    localparam logic [7:0] OFS_A_FIRST_COUNTER = 8'h13;
    localparam logic [7:0] OFS_A_FIRST_MODE = 8'h14;
    localparam logic [7:0] OFS_A_SECOND_COUNTER = 8'h15;
    localparam logic [7:0] OFS_A_SECOND_MODE = 8'h16;
    localparam logic [7:0] OFS_CTRL_B_COUNTER = 8'h41;
    localparam logic [7:0] OFS_CTRL_B_MODE = 8'h42;
    localparam logic [7:0] OFS_B_FIRST_COUNTER = 8'h43;
    localparam logic [7:0] OFS_B_FIRST_MODE = 8'h44;
    // Reset value of every mode and counter register
    localparam logic [7:0] REG_RESET = 8'h00;
    // Field positions
    localparam int SETUP_BIT = 7;
    localparam int STALL_BIT = 7;
    localparam int IN_BIT = 6;
    localparam int OUT_BIT = 5;
    localparam int ACK_BIT = 4;
    localparam int TOGGLE_BIT = 7;
    localparam int VALID_BIT = 6;
    localparam int CRC_BYTES = 2;
    localparam int NUM_EP = 5;
    // Endpoint index: 0 ctrl A, 1 A first, 2 A second, 3 ctrl B / ep3, 4 B first
    localparam logic [2:0] EP_CTRL_A = 3'h0;
    localparam logic [2:0] EP_CTRL_B = 3'h3;
    typedef enum logic [1:0] {
        TOK_SETUP = 2'b00,
        TOK_IN = 2'b01,
        TOK_OUT = 2'b10
    } token_t;
    typedef enum logic [3:0] {
        MODE_DISABLE = 4'b0000,
        MODE_NAK_IN_OUT = 4'b0001,
        MODE_STATUS_OUT = 4'b0010,
        MODE_STALL_IN_OUT = 4'b0011,
        MODE_IGNORE_IN_OUT = 4'b0100,
        MODE_ISO_OUT = 4'b0101,
        MODE_STATUS_IN = 4'b0110,
        MODE_ISO_IN = 4'b0111,
        MODE_NAK_OUT = 4'b1000,
        MODE_ACK_OUT = 4'b1001,
        MODE_NAK_OUT_ST_IN = 4'b1010,
        MODE_ACK_OUT_ST_IN = 4'b1011,
        MODE_NAK_IN = 4'b1100,
        MODE_ACK_IN = 4'b1101,
        MODE_NAK_IN_ST_OUT = 4'b1110,
        MODE_ACK_IN_ST_OUT = 4'b1111
    } mode_t;
    typedef enum logic [2:0] {
        HS_NONE = 3'b000,
        HS_ACK = 3'b001,
        HS_NAK = 3'b010,
        HS_STALL = 3'b011,
        HS_DATA = 3'b100
    } handshake_t;
endpackage
`default_nettype wire

// File: inc/engine_if.sv
`timescale 1ns/10ps
`default_nettype none
// Serial engine transaction events towards the register file
interface engine_if;
    logic tok_valid;
    logic [2:0] tok_ep;
    logic [1:0] tok_kind;
    logic data_start;
    logic done;
    logic acked;
    logic crc_ok;
    logic rx_toggle;
    logic [5:0] rx_bytes;
    modport src (output tok_valid, tok_ep, tok_kind, data_start, done, acked, crc_ok,
        rx_toggle, rx_bytes);
    modport dst (input tok_valid, tok_ep, tok_kind, data_start, done, acked, crc_ok,
        rx_toggle, rx_bytes);
endinterface
`default_nettype wire

// File: hw/mode_responder.sv
`timescale 1ns/10ps
`default_nettype none
// Handshake the engine gives for a token in a given mode
module mode_responder
    import ep_regs_pkg::*;
(
    input wire logic [3:0] mode,
    input wire logic stall,
    input wire logic [1:0] kind,
    output logic [2:0] answer
);
    always_comb begin
        answer = HS_NONE;
        case (mode)
            MODE_DISABLE: answer = HS_NONE;
            MODE_NAK_IN_OUT: answer = (kind == TOK_SETUP) ? HS_ACK : HS_NAK;
            MODE_STATUS_OUT: answer = (kind == TOK_SETUP) ? HS_ACK :
                (kind == TOK_IN) ? HS_STALL : HS_ACK;
            MODE_STALL_IN_OUT: answer = (kind == TOK_SETUP) ? HS_ACK : HS_STALL;
            MODE_IGNORE_IN_OUT: answer = (kind == TOK_SETUP) ? HS_ACK : HS_NONE;
            MODE_ISO_OUT: answer = (kind == TOK_OUT) ? HS_ACK : HS_NONE;
            MODE_STATUS_IN: answer = (kind == TOK_SETUP) ? HS_ACK :
                (kind == TOK_IN) ? HS_DATA : HS_STALL;
            MODE_ISO_IN: answer = (kind == TOK_IN) ? HS_DATA : HS_NONE;
            MODE_NAK_OUT: answer = (kind == TOK_OUT) ? HS_NAK : HS_NONE;
            MODE_ACK_OUT: answer = (kind == TOK_OUT) ? HS_ACK :
                (kind == TOK_IN && stall) ? HS_STALL : HS_NONE;
            MODE_NAK_OUT_ST_IN: answer = (kind == TOK_SETUP) ? HS_ACK :
                (kind == TOK_IN) ? HS_DATA : HS_NAK;
            MODE_ACK_OUT_ST_IN: answer = (kind == TOK_IN) ? HS_DATA : HS_ACK;
            MODE_NAK_IN: answer = (kind == TOK_IN) ? HS_NAK : HS_NONE;
            MODE_ACK_IN: answer = (kind == TOK_IN) ? (stall ? HS_STALL : HS_DATA) :
                (kind == TOK_OUT && stall) ? HS_STALL : HS_NONE;
            MODE_NAK_IN_ST_OUT: answer = (kind == TOK_IN) ? HS_NAK : HS_ACK;
            MODE_ACK_IN_ST_OUT: answer = (kind == TOK_IN) ? HS_DATA : HS_ACK;
            default: answer = HS_NONE;
        endcase
    end
endmodule
`default_nettype wire

// File: hw/usb_endpoint_mode_count_regs.sv
// Behaviour
// - Mode registers clear to zero on reset
// - Config 00/10 gives both control layouts
// - Engine sets ACK bit on acked transaction
// - Engine sets OUT flag; firmware clears it
// - Engine sets IN flag; firmware clears it
// - Any CPU write to the control mode register clears SETUP flag, except while the flag is forced high
// - SETUP flag forced high data to ACK
// - Engine update locks control bits six..zero
// - CPU read releases control mode lock
// - Only control endpoint mode and counter registers lock
// - SETUP flag blocks control FIFO writes
// - Low four bits select token response
// - Stall bit stalls opposite direction, and IN as well in ACK IN mode
// - Hardware count is bytes plus two
// - Data valid follows CRC; interrupt regardless
// - Toggle bit copies received data toggle
// - Control counter locks until read
// - Five-endpoint config makes B0 endpoint 3
// - ACK moves ACK mode to NAK mode
// - Mode 0000 ignores all traffic
`timescale 1ns/10ps
`default_nettype none
module usb_endpoint_mode_count_regs
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // CPU I/O port
    input wire logic [7:0] io_addr,
    input wire logic io_read_op,
    input wire logic io_write_op,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    // Endpoint configuration bits from status and control register
    input wire logic [1:0] ep_config,
    // Serial engine transaction events
    input wire logic tok_valid,
    input wire logic [2:0] tok_ep,
    input wire ep_regs_pkg::token_t tok_kind,
    input wire logic data_start,
    input wire logic done,
    input wire logic acked,
    input wire logic crc_ok,
    input wire logic rx_toggle,
    input wire logic [5:0] rx_bytes,
    // Handshake decision for the current token
    output ep_regs_pkg::handshake_t answer,
    // Endpoint FIFO write path from CPU
    input wire logic fifo_wr_req,
    input wire logic [2:0] fifo_wr_ep,
    output logic fifo_wr_allow,
    // Endpoint interrupt flags
    output logic [4:0] ep_irq
);
    import ep_regs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Reset release
    logic rst_meta;
    logic rst_sync;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Engine events through the carrier
    engine_if eng ();
    assign eng.tok_valid = tok_valid;
    assign eng.tok_ep = tok_ep;
    assign eng.tok_kind = tok_kind;
    assign eng.data_start = data_start;
    assign eng.done = done;
    assign eng.acked = acked;
    assign eng.crc_ok = crc_ok;
    assign eng.rx_toggle = rx_toggle;
    assign eng.rx_bytes = rx_bytes;

    logic [7:0] mode_reg [NUM_EP];
    logic [7:0] count_reg [NUM_EP];
    logic [NUM_EP-1:0] mode_lock;
    logic [NUM_EP-1:0] count_lock;
    logic [NUM_EP-1:0] setup_force;
    logic [2:0] cur_ep;
    token_t cur_kind;
    logic five_ep;
    assign five_ep = ep_config[0];

    // Control layout applies at A0 always and at B0 only in two-address mode
    function automatic logic is_ctrl(input int idx, input logic five);
        return (idx == int'(EP_CTRL_A)) || (idx == int'(EP_CTRL_B) && !five);
    endfunction

    // ACK modes fall back to their NAK partner
    function automatic logic [3:0] after_ack(input logic [3:0] m);
        if (m == MODE_ACK_OUT || m == MODE_ACK_OUT_ST_IN || m == MODE_ACK_IN ||
                m == MODE_ACK_IN_ST_OUT) begin
            return {m[3:1], 1'b0};
        end
        return m;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Latch the token in flight
    always_ff @(posedge sys_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            cur_ep <= 3'h0;
            cur_kind <= TOK_SETUP;
        end else if (eng.tok_valid) begin
            cur_ep <= eng.tok_ep;
            cur_kind <= token_t'(eng.tok_kind);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Token response
    logic [7:0] resp_mode;
    assign resp_mode = mode_reg[eng.tok_ep < 3'(NUM_EP) ? eng.tok_ep : 3'h0];
    logic [2:0] raw_answer;
    mode_responder u_resp (
        .mode(resp_mode[3:0]),
        .stall(resp_mode[STALL_BIT] && !is_ctrl(int'(eng.tok_ep), five_ep)),
        .kind(eng.tok_kind),
        .answer(raw_answer)
    );
    assign answer = handshake_t'(raw_answer);

    ////////////////////////////////////////////////////////////////////////////
    // Per-endpoint registers
    genvar g;
    generate
        for (g = 0; g < NUM_EP; g++) begin : g_ep
            localparam logic [7:0] MODE_OFS = (g == 0) ? OFS_CTRL_A_MODE :
                (g == 1) ? OFS_A_FIRST_MODE : (g == 2) ? OFS_A_SECOND_MODE :
                (g == 3) ? OFS_CTRL_B_MODE : OFS_B_FIRST_MODE;
            localparam logic [7:0] CNT_OFS = (g == 0) ? OFS_CTRL_A_COUNTER :
                (g == 1) ? OFS_A_FIRST_COUNTER : (g == 2) ? OFS_A_SECOND_COUNTER :
                (g == 3) ? OFS_CTRL_B_COUNTER : OFS_B_FIRST_COUNTER;
            logic ctrl;
            logic upd;
            logic wr_m;
            logic wr_c;
            logic rd_m;
            logic rd_c;
            assign ctrl = is_ctrl(g, five_ep);
            assign upd = eng.done && cur_ep == 3'(g);
            assign wr_m = io_write_op && io_addr == MODE_OFS;
            assign wr_c = io_write_op && io_addr == CNT_OFS;
            assign rd_m = io_read_op && io_addr == MODE_OFS;
            assign rd_c = io_read_op && io_addr == CNT_OFS;

            // Forced SETUP window from data start to handshake
            always_ff @(posedge sys_clk or negedge rst_sync) begin
                if (!rst_sync) begin
                    setup_force[g] <= 1'b0;
                end else if (ctrl && eng.data_start && cur_ep == 3'(g) &&
                        cur_kind == TOK_SETUP) begin
                    setup_force[g] <= 1'b1;
                end else if (upd) begin
                    setup_force[g] <= 1'b0;
                end
            end

            // Mode lock: set on update, released by read
            always_ff @(posedge sys_clk or negedge rst_sync) begin
                if (!rst_sync) begin
                    mode_lock[g] <= 1'b0;
                end else if (upd && ctrl) begin
                    mode_lock[g] <= 1'b1;
                end else if (rd_m || !ctrl) begin
                    mode_lock[g] <= 1'b0;
                end
            end

            // Counter lock on SETUP or OUT update of control endpoint
            always_ff @(posedge sys_clk or negedge rst_sync) begin
                if (!rst_sync) begin
                    count_lock[g] <= 1'b0;
                end else if (upd && ctrl && cur_kind != TOK_IN) begin
                    count_lock[g] <= 1'b1;
                end else if (rd_c || !ctrl) begin
                    count_lock[g] <= 1'b0;
                end
            end

            // Mode register
            always_ff @(posedge sys_clk or negedge rst_sync) begin
                if (!rst_sync) begin
                    mode_reg[g] <= REG_RESET;
                end else begin
                    if (wr_m && !(ctrl && mode_lock[g])) begin
                        mode_reg[g][6:0] <= io_wdata[6:0];
                    end
                    if (wr_m && !ctrl) begin
                        mode_reg[g][STALL_BIT] <= io_wdata[STALL_BIT];
                    end else if (wr_m && ctrl) begin
                        mode_reg[g][SETUP_BIT] <= 1'b0;
                    end
                    if (ctrl && eng.tok_valid && eng.tok_ep == 3'(g) &&
                            resp_mode[3:0] != 4'h0) begin
                        if (eng.tok_kind == TOK_OUT) mode_reg[g][OUT_BIT] <= 1'b1;
                        if (eng.tok_kind == TOK_IN) mode_reg[g][IN_BIT] <= 1'b1;
                    end
                    if (ctrl && setup_force[g]) begin
                        mode_reg[g][SETUP_BIT] <= 1'b1;
                    end
                    if (upd && eng.acked) begin
                        mode_reg[g][ACK_BIT] <= 1'b1;
                        mode_reg[g][3:0] <= after_ack(mode_reg[g][3:0]);
                    end
                end
            end

            // Counter register
            always_ff @(posedge sys_clk or negedge rst_sync) begin
                if (!rst_sync) begin
                    count_reg[g] <= REG_RESET;
                end else if (upd && cur_kind != TOK_IN) begin
                    count_reg[g][TOGGLE_BIT] <= eng.rx_toggle;
                    count_reg[g][VALID_BIT] <= eng.crc_ok;
                    count_reg[g][5:0] <= eng.rx_bytes + 6'(CRC_BYTES);
                end else if (wr_c && !(ctrl && count_lock[g])) begin
                    count_reg[g] <= io_wdata;
                end
            end

            // Endpoint interrupt on every completed transaction
            always_ff @(posedge sys_clk or negedge rst_sync) begin
                if (!rst_sync) begin
                    ep_irq[g] <= 1'b0;
                end else begin
                    ep_irq[g] <= upd;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // CPU read data
    always_ff @(posedge sys_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            io_rdata <= 8'h00;
        end else begin
            case (io_addr)
                OFS_CTRL_A_MODE: io_rdata <= mode_reg[0];
                OFS_A_FIRST_MODE: io_rdata <= mode_reg[1];
                OFS_A_SECOND_MODE: io_rdata <= mode_reg[2];
                OFS_CTRL_B_MODE: io_rdata <= mode_reg[3];
                OFS_B_FIRST_MODE: io_rdata <= mode_reg[4];
                OFS_CTRL_A_COUNTER: io_rdata <= count_reg[0];
                OFS_A_FIRST_COUNTER: io_rdata <= count_reg[1];
                OFS_A_SECOND_COUNTER: io_rdata <= count_reg[2];
                OFS_CTRL_B_COUNTER: io_rdata <= count_reg[3];
                OFS_B_FIRST_COUNTER: io_rdata <= count_reg[4];
                default: io_rdata <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // FIFO write guard
    always_comb begin
        fifo_wr_allow = fifo_wr_req;
        if (fifo_wr_ep == EP_CTRL_A && mode_reg[0][SETUP_BIT]) begin
            fifo_wr_allow = 1'b0;
        end
        if (fifo_wr_ep == EP_CTRL_B && !five_ep && mode_reg[3][SETUP_BIT]) begin
            fifo_wr_allow = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence setup_tok_s;
        tok_valid && tok_ep == EP_CTRL_A && tok_kind == TOK_SETUP;
    endsequence

    sequence setup_data_s;
        data_start && tok_valid == 1'b0;
    endsequence

    property fifo_block_p;
        @(posedge sys_clk) disable iff (!rst_sync)
        mode_reg[0][SETUP_BIT] && fifo_wr_ep == EP_CTRL_A |-> !fifo_wr_allow;
    endproperty
    fifo_block_a: assert property (fifo_block_p) else $error("fifo write while setup");

    mode_reset_a: assert property (@(posedge sys_clk) $rose(rst_sync) |-> mode_reg[0] == 8'h00)
        else $error("mode not cleared");

    ack_to_nak_a: assert property (@(posedge sys_clk) disable iff (!rst_sync)
        done && acked && cur_ep == 3'h1 && mode_reg[1][3:0] == MODE_ACK_OUT
        |=> mode_reg[1][3:0] == MODE_NAK_OUT) else $error("ack mode not dropped");

    ack_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_sync)
        done && acked && cur_ep == 3'h2 |=> mode_reg[2][ACK_BIT]) else $error("ack flag");

    count_plus_a: assert property (@(posedge sys_clk) disable iff (!rst_sync)
        done && cur_ep == 3'h1 && cur_kind == TOK_OUT
        |=> count_reg[1][5:0] == $past(rx_bytes) + 6'd2) else $error("count wrong");

    valid_crc_a: assert property (@(posedge sys_clk) disable iff (!rst_sync)
        done && cur_ep == 3'h4 && cur_kind != TOK_IN
        |=> count_reg[4][VALID_BIT] == $past(crc_ok) && ep_irq[4]) else $error("crc");

    lock_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_sync)
        mode_lock[0] && !done && !setup_force[0] && !tok_valid
        |=> mode_reg[0][6:0] == $past(mode_reg[0][6:0])) else $error("lock");

    read_unlock_a: assert property (@(posedge sys_clk) disable iff (!rst_sync)
        io_read_op && io_addr == OFS_CTRL_A_MODE && !done |=> !mode_lock[0])
        else $error("unlock");

    other_free_a: assert property (@(posedge sys_clk) disable iff (!rst_sync)
        !mode_lock[1] && !count_lock[2]) else $error("lock on data ep");

    cnt_lock_a: assert property (@(posedge sys_clk) disable iff (!rst_sync)
        done && cur_ep == 3'h0 && cur_kind == TOK_OUT |=> count_lock[0])
        else $error("count lock");

    setup_hi_a: assert property (@(posedge sys_clk) disable iff (!rst_sync)
        setup_tok_s ##1 setup_data_s |=> ##1 mode_reg[0][SETUP_BIT])
        else $error("setup low");

    setup_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_sync)
        setup_force[0] |=> mode_reg[0][SETUP_BIT])
        else $error("setup not held");
endmodule
`default_nettype wire

// File: tb/engine_model.sv
`timescale 1ns/10ps
`default_nettype none
// Stand-in for the serial engine and host traffic
module engine_model
(
    // Clock
    input wire logic sys_clk,
    // Transaction events
    output logic tok_valid,
    output logic [2:0] tok_ep,
    output var ep_regs_pkg::token_t tok_kind,
    output logic data_start,
    output logic done,
    output logic acked,
    output logic crc_ok,
    output logic rx_toggle,
    output logic [5:0] rx_bytes,
    // Handshake decision
    input wire ep_regs_pkg::handshake_t answer
);
    import ep_regs_pkg::*;
    initial begin
        tok_valid = 1'b0;
        tok_ep = 3'h0;
        tok_kind = TOK_SETUP;
        data_start = 1'b0;
        done = 1'b0;
        acked = 1'b0;
        crc_ok = 1'b0;
        rx_toggle = 1'b0;
        rx_bytes = 6'h00;
    end
    // Token pulse, handshake sampled once settled
    task automatic token(input logic [2:0] ep, input token_t k, output handshake_t a);
        @(negedge sys_clk);
        tok_valid = 1'b1;
        tok_ep = ep;
        tok_kind = k;
        #1 a = answer;
        @(negedge sys_clk);
        tok_valid = 1'b0;
    endtask
    // Data packet start
    task automatic data();
        data_start = 1'b1;
        @(negedge sys_clk);
        data_start = 1'b0;
    endtask
    // Transaction end; qualifiers scrambled once released
    task automatic finish(input logic ack, input logic crc, input logic tog,
        input logic [5:0] n);
        @(negedge sys_clk);
        done = 1'b1;
        acked = ack;
        crc_ok = crc;
        rx_toggle = tog;
        rx_bytes = n;
        @(negedge sys_clk);
        done = 1'b0;
        acked = ~acked;
        crc_ok = ~crc_ok;
        rx_toggle = ~rx_toggle;
        rx_bytes = ~rx_bytes;
    endtask
endmodule
`default_nettype wire

// File: tb/usb_endpoint_mode_count_regs_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module usb_endpoint_mode_count_regs_tb_top;
    import ep_regs_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] io_addr = 8'h00;
    logic io_read_op = 1'b0;
    logic io_write_op = 1'b0;
    logic [7:0] io_wdata = 8'h00;
    logic [7:0] io_rdata;
    logic [1:0] ep_config = 2'b00;
    logic tok_valid, data_start, done, acked, crc_ok, rx_toggle;
    logic [2:0] tok_ep;
    token_t tok_kind;
    logic [5:0] rx_bytes;
    handshake_t answer, hs;
    logic fifo_wr_req = 1'b1;
    logic [2:0] fifo_wr_ep = 3'h0;
    logic fifo_wr_allow;
    logic [4:0] ep_irq;
    logic [7:0] d;
    logic seen;
    int n_fail = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [7:0] rows [10][3] = '{
        '{8'h14, 8'h8F, 8'h8F}, '{8'h16, 8'h9E, 8'h9E}, '{8'h44, 8'h1C, 8'h1C},
        '{8'h13, 8'hA0, 8'hA0}, '{8'h15, 8'h3F, 8'h3F}, '{8'h41, 8'h60, 8'h60},
        '{8'h43, 8'h22, 8'h22}, '{8'h11, 8'h81, 8'h81}, '{8'h12, 8'hCF, 8'h4F},
        '{8'h42, 8'hB3, 8'h33}};

    always #25 sys_clk = ~sys_clk;

    usb_endpoint_mode_count_regs usb_endpoint_mode_count_regs_inst (
        .sys_clk(sys_clk), .rst_b(rst_b), .io_addr(io_addr), .io_read_op(io_read_op),
        .io_write_op(io_write_op), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .ep_config(ep_config), .tok_valid(tok_valid), .tok_ep(tok_ep), .tok_kind(tok_kind),
        .data_start(data_start), .done(done), .acked(acked), .crc_ok(crc_ok),
        .rx_toggle(rx_toggle), .rx_bytes(rx_bytes), .answer(answer),
        .fifo_wr_req(fifo_wr_req), .fifo_wr_ep(fifo_wr_ep), .fifo_wr_allow(fifo_wr_allow),
        .ep_irq(ep_irq));

    engine_model engine_model_inst (
        .sys_clk(sys_clk), .tok_valid(tok_valid), .tok_ep(tok_ep), .tok_kind(tok_kind),
        .data_start(data_start), .done(done), .acked(acked), .crc_ok(crc_ok),
        .rx_toggle(rx_toggle), .rx_bytes(rx_bytes), .answer(answer));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge sys_clk);
        io_addr = a;
        io_wdata = v;
        io_write_op = 1'b1;
        @(negedge sys_clk);
        io_write_op = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge sys_clk);
        io_addr = a;
        io_read_op = 1'b1;
        @(negedge sys_clk);
        io_read_op = 1'b0;
        v = io_rdata;
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(negedge sys_clk);
        rst_b = 1'b1;
        repeat (4) @(negedge sys_clk);
        foreach (rows[i]) begin
            rd(rows[i][0], d);
            chk(d, 8'h00);
            wr(rows[i][0], rows[i][1]);
            rd(rows[i][0], d);
            chk(d, rows[i][2]);
        end
        $display("table test done");
        // SETUP on the address A control endpoint
        wr(8'h12, 8'h01);
        engine_model_inst.token(3'h0, TOK_SETUP, hs);
        engine_model_inst.data();
        rd(8'h12, d);
        chk(d & 8'h80, 8'h80);
        #1 chk({7'h0, fifo_wr_allow}, 8'h00);
        @(negedge sys_clk);
        fifo_wr_ep = 3'h1;
        #1 chk({7'h0, fifo_wr_allow}, 8'h01);
        @(negedge sys_clk);
        fifo_wr_ep = 3'h0;
        engine_model_inst.finish(1'b1, 1'b1, 1'b0, 6'd8);
        rd(8'h11, d);
        chk(d, 8'h4A);
        rd(8'h12, d);
        chk(d & 8'h90, 8'h90);
        wr(8'h12, 8'h00);
        rd(8'h12, d);
        chk(d & 8'h80, 8'h00);
        #1 chk({7'h0, fifo_wr_allow}, 8'h01);
        $display("setup test done");
        // OUT with bad CRC, then lock and unlock
        wr(8'h12, 8'h09);
        rd(8'h12, d);
        chk(d, 8'h09);
        engine_model_inst.token(3'h0, TOK_OUT, hs);
        chk({5'h0, hs}, {5'h0, HS_ACK});
        engine_model_inst.data();
        engine_model_inst.finish(1'b1, 1'b0, 1'b1, 6'd4);
        seen = ep_irq[0];
        @(negedge sys_clk);
        seen = seen | ep_irq[0];
        chk({7'h0, seen}, 8'h01);
        wr(8'h11, 8'h05);
        wr(8'h12, 8'h01);
        rd(8'h12, d);
        chk(d, 8'h38);
        rd(8'h11, d);
        chk(d, 8'h86);
        wr(8'h12, 8'h01);
        wr(8'h11, 8'h05);
        rd(8'h12, d);
        chk(d, 8'h01);
        rd(8'h11, d);
        chk(d, 8'h05);
        $display("lock test done");
        // Non-control endpoint never locks; stall and disable answers
        wr(8'h14, 8'h09);
        engine_model_inst.token(3'h1, TOK_OUT, hs);
        engine_model_inst.data();
        engine_model_inst.finish(1'b1, 1'b1, 1'b0, 6'd0);
        wr(8'h13, 8'h11);
        wr(8'h14, 8'h8D);
        rd(8'h13, d);
        chk(d, 8'h11);
        rd(8'h14, d);
        chk(d, 8'h8D);
        engine_model_inst.token(3'h1, TOK_OUT, hs);
        chk({5'h0, hs}, {5'h0, HS_STALL});
        engine_model_inst.finish(1'b0, 1'b1, 1'b0, 6'd0);
        wr(8'h14, 8'h00);
        engine_model_inst.token(3'h1, TOK_IN, hs);
        chk({5'h0, hs}, {5'h0, HS_NONE});
        engine_model_inst.finish(1'b0, 1'b1, 1'b0, 6'd0);
        // Layout of the address B endpoint zero location
        ep_config = 2'b01;
        wr(8'h42, 8'h80);
        rd(8'h42, d);
        chk(d, 8'h80);
        ep_config = 2'b00;
        wr(8'h42, 8'h80);
        rd(8'h42, d);
        chk(d, 8'h00);
        $display("layout test done");
        stop_test();
    end
endmodule
`default_nettype wire
